/* rtl/iscs_params.svh */
`ifndef ISCS_PARAMS_SVH
`define ISCS_PARAMS_SVH
`define ISCS_OP_SERVICE_RETURN 7'h03
`define ISCS_OP_LATCHED        7'h17
`define ISCS_OP_LIMIT_PTR_LOAD 7'h1D
`define ISCS_OP_TRANSPARENT    7'h37
`define ISCS_OP_VECTOR_WRITE   7'h0D
`define ISCS_OP_STACK_DEC      7'h02
`define ISCS_OP_STACK_POP      7'h3E
`define ISCS_OP_STACK_PUSH     7'h1E
`define ISCS_OP_PTR_READ       7'h2C
`define ISCS_OP_PTR_WRITE      7'h0E
`define ISCS_RAM_DEPTH         64
`define ISCS_VEC_DEPTH         16
`define ISCS_LIMIT_LSB         2
`define ISCS_LIMIT_MSB         5
`define ISCS_VECPTR_LSB        12
`define ISCS_VECPTR_MSB        15
`define ISCS_RST_STATUS0       1'b0
`define ISCS_RST_PTR           6'h3F
`endif

/* rtl/iscs_pkg.sv */
package iscs_pkg;
    typedef logic [6:0]  iscs_op_t;
    typedef logic [15:0] iscs_word_t;
    typedef logic [5:0]  iscs_ptr_t;
    typedef struct packed {
        logic       valid;
        iscs_op_t   op;
        iscs_word_t pc;
    } iscs_instr_t;
    typedef struct packed {
        logic       transparent;
        logic [8:1] extLatch;
        logic       limitLatch;
        logic       inProgress;
        logic [3:0] current;
        iscs_ptr_t  stackPtr;
        logic [3:0] limitVal;
        logic [3:0] vecPtr;
        iscs_word_t dataOut;
        logic       dataOe;
        iscs_word_t nextAddr;
    } iscs_state_t;
endpackage

/* rtl/iscs_core.sv */
`timescale 1ns/10ps
`default_nettype none
`include "iscs_params.svh"
module iscs_core #(
    parameter int RAM_DEPTH = `ISCS_RAM_DEPTH,
    parameter int VEC_DEPTH = `ISCS_VEC_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire iscs_pkg::iscs_instr_t instr,
    input  wire logic [15:0]       dataIn,
    output logic [15:0]            dataOut,
    output logic                   dataOeN,
    input  wire logic [8:1]        extReq,
    input  wire logic              limitSet,
    input  wire logic              recognize,
    input  wire logic [3:0]        recognizedLevel,
    output logic [8:1]             extPending,
    output logic                   limitPending,
    output logic                   serviceInProgress,
    output logic                   transparentMode,
    output logic [5:0]             stackBoundary,
    output logic [15:0]            nextAddr,
    output logic [3:0]             vectorPointer,
    output logic [15:0]            vectorOut
);
    import iscs_pkg::*;

    iscs_state_t st_r;
    iscs_state_t st_nxt;
    logic [15:0] stackRam [RAM_DEPTH];
    logic [15:0] vecFile  [VEC_DEPTH];
    logic [8:1]  reqSyncA_r;
    logic [8:1]  reqSyncB_r;
    logic [8:5]  hiCapt_r;
    logic [4:1]  loCapt_r;
    logic        ramWe;
    iscs_ptr_t   ramAddr;
    logic        vecWe;

    function automatic logic isOp(input iscs_instr_t i, input iscs_op_t o);
        return i.valid && i.op == o;
    endfunction

    // Two-stage synchroniser on the request pins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reqSyncA_r <= '0;
            reqSyncB_r <= '0;
        end else begin
            reqSyncA_r <= extReq;
            reqSyncB_r <= reqSyncA_r;
        end
    end

    // High phase group sampled at rising edge, low group at falling
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) hiCapt_r <= '0;
        else       hiCapt_r <= reqSyncB_r[8:5];
    end
    always_ff @(negedge clk or negedge rstn) begin
        if (!rstn) loCapt_r <= '0;
        else       loCapt_r <= reqSyncB_r[4:1];
    end

    always_comb begin
        st_nxt          = st_r;
        st_nxt.dataOe   = 1'b0;
        st_nxt.nextAddr = instr.pc + 16'h0001;
        ramWe           = 1'b0;
        ramAddr         = st_r.stackPtr;
        vecWe           = 1'b0;
        if (limitSet) st_nxt.limitLatch = 1'b1;
        if (isOp(instr, `ISCS_OP_SERVICE_RETURN)) begin
            if (st_r.current inside {[4'h1:4'h8]})
                st_nxt.extLatch[st_r.current] = 1'b0;
            st_nxt.inProgress = 1'b0;
            st_nxt.nextAddr   = stackRam[st_r.stackPtr];
            st_nxt.stackPtr   = st_r.stackPtr - 6'h01;
        end
        // A recognition in the same cycle outranks the return's clear
        if (recognize) begin
            st_nxt.inProgress = 1'b1;
            st_nxt.current    = recognizedLevel;
        end
        // Capture ignores masking; a fresh request outranks the return's clear
        if (!st_r.transparent)
            st_nxt.extLatch = st_nxt.extLatch | {hiCapt_r, loCapt_r};
        else
            st_nxt.extLatch = '0;
        if (isOp(instr, `ISCS_OP_LATCHED))
            st_nxt.transparent = 1'b0;
        if (isOp(instr, `ISCS_OP_TRANSPARENT)) begin
            st_nxt.transparent = 1'b1;
            st_nxt.extLatch    = '0;
        end
        if (isOp(instr, `ISCS_OP_LIMIT_PTR_LOAD)) begin
            st_nxt.limitVal =
                dataIn[`ISCS_LIMIT_MSB:`ISCS_LIMIT_LSB];
            st_nxt.vecPtr =
                dataIn[`ISCS_VECPTR_MSB:`ISCS_VECPTR_LSB];
            st_nxt.limitLatch = 1'b0;
        end
        if (isOp(instr, `ISCS_OP_VECTOR_WRITE)) begin
            vecWe         = 1'b1;
            st_nxt.vecPtr = st_r.vecPtr + 4'h1;
        end
        if (isOp(instr, `ISCS_OP_STACK_DEC))
            st_nxt.stackPtr = st_r.stackPtr - 6'h01;
        if (isOp(instr, `ISCS_OP_STACK_POP)) begin
            st_nxt.dataOut  = stackRam[st_r.stackPtr];
            st_nxt.dataOe   = 1'b1;
            st_nxt.stackPtr = st_r.stackPtr - 6'h01;
        end
        if (isOp(instr, `ISCS_OP_STACK_PUSH)) begin
            st_nxt.stackPtr = st_r.stackPtr + 6'h01;
            ramAddr         = st_r.stackPtr + 6'h01;
            ramWe           = 1'b1;
        end
        if (isOp(instr, `ISCS_OP_PTR_READ)) begin
            st_nxt.dataOut = {10'h000, st_r.stackPtr};
            st_nxt.dataOe  = 1'b1;
        end
        if (isOp(instr, `ISCS_OP_PTR_WRITE))
            st_nxt.stackPtr = dataIn[5:0];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r          <= '0;
            st_r.stackPtr <= `ISCS_RST_PTR;
            st_r.transparent <= `ISCS_RST_STATUS0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (ramWe) stackRam[ramAddr] <= dataIn;
        if (vecWe) vecFile[st_r.vecPtr] <= dataIn;
    end

    assign dataOut           = st_r.dataOut;
    assign dataOeN           = ~st_r.dataOe;
    assign extPending        = st_r.extLatch;
    assign limitPending      = st_r.limitLatch;
    assign serviceInProgress = st_r.inProgress;
    assign transparentMode   = st_r.transparent;
    assign stackBoundary     = {st_r.limitVal, 2'b00};
    assign nextAddr          = st_r.nextAddr;
    assign vectorPointer     = st_r.vecPtr;
    assign vectorOut         = vecFile[st_r.vecPtr];

    property p_ret_clears;
        @(posedge clk) disable iff (!rstn)
        isOp(instr, `ISCS_OP_SERVICE_RETURN) && !recognize |=> !serviceInProgress;
    endproperty
    a_ret_clears: assert property (p_ret_clears) else $error("ret");
    property p_ret_keeps;
        @(posedge clk) disable iff (!rstn)
        isOp(instr, `ISCS_OP_SERVICE_RETURN) && !limitSet &&
        !isOp(instr, `ISCS_OP_LIMIT_PTR_LOAD) |=> $stable(limitPending);
    endproperty
    a_ret_keeps: assert property (p_ret_keeps) else $error("keep");
    property p_trans;
        @(posedge clk) disable iff (!rstn)
        isOp(instr, `ISCS_OP_TRANSPARENT) |=> transparentMode && extPending == 0;
    endproperty
    a_trans: assert property (p_trans) else $error("trans");
    property p_latch;
        @(posedge clk) disable iff (!rstn)
        isOp(instr, `ISCS_OP_LATCHED) |=> !transparentMode;
    endproperty
    a_latch: assert property (p_latch) else $error("latch");
    property p_limit;
        @(posedge clk) disable iff (!rstn)
        isOp(instr, `ISCS_OP_LIMIT_PTR_LOAD) && !limitSet |=>
        stackBoundary == {$past(dataIn[5:2]), 2'b00} && !limitPending;
    endproperty
    a_limit: assert property (p_limit) else $error("limit");
    property p_dec;
        @(posedge clk) disable iff (!rstn)
        isOp(instr, `ISCS_OP_STACK_DEC) |=>
        st_r.stackPtr == $past(st_r.stackPtr) - 6'h01;
    endproperty
    a_dec: assert property (p_dec) else $error("dec");
    property p_push;
        @(posedge clk) disable iff (!rstn)
        isOp(instr, `ISCS_OP_STACK_PUSH) |=>
        st_r.stackPtr == $past(st_r.stackPtr) + 6'h01;
    endproperty
    a_push: assert property (p_push) else $error("push");
    property p_rd;
        @(posedge clk) disable iff (!rstn)
        isOp(instr, `ISCS_OP_PTR_READ) |=>
        !dataOeN && dataOut[5:0] == $past(st_r.stackPtr);
    endproperty
    a_rd: assert property (p_rd) else $error("rd");
    property p_vec;
        @(posedge clk) disable iff (!rstn)
        isOp(instr, `ISCS_OP_VECTOR_WRITE) |=>
        vectorPointer == $past(vectorPointer) + 4'h1;
    endproperty
    a_vec: assert property (p_vec) else $error("vec");

    // Return pops the call stack as it hands over the address
    sequence s_ret;
        isOp(instr, `ISCS_OP_SERVICE_RETURN) && !recognize;
    endsequence
    property p_ret_pop;
        @(posedge clk) disable iff (!rstn)
        s_ret |=> st_r.stackPtr == $past(st_r.stackPtr) - 6'h01;
    endproperty
    a_ret_pop: assert property (p_ret_pop) else $error("ret pop");

    property p_pop;
        @(posedge clk) disable iff (!rstn)
        isOp(instr, `ISCS_OP_STACK_POP) |=>
        !dataOeN && st_r.stackPtr == $past(st_r.stackPtr) - 6'h01;
    endproperty
    a_pop: assert property (p_pop) else $error("pop");

    property p_ptr_wr;
        @(posedge clk) disable iff (!rstn)
        isOp(instr, `ISCS_OP_PTR_WRITE) |=>
        st_r.stackPtr == $past(dataIn[5:0]);
    endproperty
    a_ptr_wr: assert property (p_ptr_wr) else $error("ptr wr");

    property p_pc;
        @(posedge clk) disable iff (!rstn)
        !isOp(instr, `ISCS_OP_SERVICE_RETURN) |=>
        nextAddr == $past(instr.pc) + 16'h0001;
    endproperty
    a_pc: assert property (p_pc) else $error("next addr");

    property p_no_read;
        @(posedge clk) disable iff (!rstn)
        isOp(instr, `ISCS_OP_LIMIT_PTR_LOAD) ||
        isOp(instr, `ISCS_OP_VECTOR_WRITE) |=> dataOeN;
    endproperty
    a_no_read: assert property (p_no_read) else $error("no read");

    // Latched bits only drop on a return or a switch to transparent
    property p_hold;
        @(posedge clk) disable iff (!rstn)
        !transparentMode && !isOp(instr, `ISCS_OP_SERVICE_RETURN) &&
        !isOp(instr, `ISCS_OP_TRANSPARENT) |=>
        (extPending & $past(extPending)) == $past(extPending);
    endproperty
    a_hold: assert property (p_hold) else $error("latch hold");

    property p_tr_empty;
        @(posedge clk) disable iff (!rstn)
        transparentMode |-> extPending == 8'h00;
    endproperty
    a_tr_empty: assert property (p_tr_empty) else $error("empty");

    // A push followed at once by a pop returns the pushed word
    sequence s_push;
        isOp(instr, `ISCS_OP_STACK_PUSH);
    endsequence
    sequence s_pop;
        isOp(instr, `ISCS_OP_STACK_POP);
    endsequence
    property p_round;
        @(posedge clk) disable iff (!rstn)
        s_push ##1 s_pop |=> !dataOeN && dataOut == $past(dataIn, 2);
    endproperty
    a_round: assert property (p_round) else $error("round");

    property p_wrap;
        @(posedge clk) disable iff (!rstn)
        isOp(instr, `ISCS_OP_STACK_PUSH) && st_r.stackPtr == 6'h3F |=>
        st_r.stackPtr == 6'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap");

    property p_vecload;
        @(posedge clk) disable iff (!rstn)
        isOp(instr, `ISCS_OP_LIMIT_PTR_LOAD) |=>
        vectorPointer == $past(dataIn[15:12]);
    endproperty
    a_vecload: assert property (p_vecload) else $error("vec load");
endmodule
`default_nettype wire

/* tb/iscs_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none
module iscs_bus_model (
    input  wire logic                 clk,
    output var iscs_pkg::iscs_instr_t instr,
    output var iscs_pkg::iscs_word_t  dataIn
);
    import iscs_pkg::*;
    iscs_word_t pcNow;
    initial begin
        instr = '0;
        dataIn = 16'h0000;
        pcNow = 16'h1000;
    end
    // One microcode word per cycle, operand on the data bus with it
    task automatic issue(input iscs_op_t op, input iscs_word_t d);
        @(posedge clk);
        #1;
        pcNow = pcNow + 16'h0001;
        instr = '{valid: 1'b1, op: op, pc: pcNow};
        dataIn = d;
    endtask
    // A released bus must not look like the last word
    task automatic idle();
        @(posedge clk);
        #1;
        instr.valid = 1'b0;
        dataIn = ~dataIn;
    endtask
endmodule
`default_nettype wire

/* tb/iscs_core_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "iscs_params.svh"
`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module iscs_core_tb;
    import iscs_pkg::*;
    logic        clk, rstn, limitSet, recognize, dataOeN;
    logic        limitPending, serviceInProgress, transparentMode;
    logic [3:0]  recognizedLevel, vectorPointer;
    logic [8:1]  extReq, extPending;
    logic [5:0]  stackBoundary;
    logic [15:0] dataOut, nextAddr, vectorOut;
    iscs_instr_t instr;
    iscs_word_t  dataIn;
    int          bad_count = 0;
    int          cmp_count = 0;
    iscs_bus_model bus (.clk, .instr, .dataIn);
    iscs_core dut (.clk, .rstn, .instr, .dataIn, .dataOut, .dataOeN,
        .extReq, .limitSet, .recognize, .recognizedLevel, .extPending,
        .limitPending, .serviceInProgress, .transparentMode,
        .stackBoundary, .nextAddr, .vectorPointer, .vectorOut);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic print_verdict();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic run(input iscs_op_t op, input iscs_word_t d);
        bus.issue(op, d);
        bus.idle();
    endtask
    task automatic ptrChk(input iscs_ptr_t exp);
        run(`ISCS_OP_PTR_READ, 16'h0000);
        `CHK(dataOut[5:0], exp)
        `CHK(dataOeN, 1'b0)
    endtask
    task automatic pulseSet();
        @(posedge clk);
        #1 limitSet = 1'b1;
        @(posedge clk);
        #1 limitSet = 1'b0;
    endtask
    task automatic reqPulse(input logic [8:1] r);
        @(posedge clk);
        #1 extReq = r;
        repeat (2) @(posedge clk);
        #1 extReq = 8'h00;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic stack_wrap();
        ptrChk(6'h3F);
        `CHK(nextAddr, bus.pcNow + 16'h0001)
        bus.issue(`ISCS_OP_STACK_PUSH, 16'hA5A5);
        bus.issue(`ISCS_OP_STACK_PUSH, 16'h1234);
        ptrChk(6'h01);
        bus.issue(`ISCS_OP_STACK_POP, 16'h0000);
        bus.issue(`ISCS_OP_STACK_POP, 16'h0000);
        `CHK(dataOut, 16'h1234)
        bus.idle();
        `CHK(dataOut, 16'hA5A5)
        ptrChk(6'h3F);
    endtask
    task automatic stack_dec();
        run(`ISCS_OP_PTR_WRITE, 16'hFFC2);
        run(`ISCS_OP_STACK_PUSH, 16'hBEEF);
        run(`ISCS_OP_STACK_DEC, 16'h0000);
        ptrChk(6'h02);
        run(`ISCS_OP_PTR_WRITE, 16'h0003);
        run(`ISCS_OP_STACK_POP, 16'h0000);
        `CHK(dataOut, 16'hBEEF)
        bus.issue(`ISCS_OP_STACK_PUSH, 16'h7E57);
        bus.issue(`ISCS_OP_STACK_POP, 16'h0000);
        bus.idle();
        `CHK(dataOut, 16'h7E57)
    endtask
    task automatic limit_vector();
        pulseSet();
        `CHK(limitPending, 1'b1)
        run(`ISCS_OP_LIMIT_PTR_LOAD, 16'hAFE7);
        `CHK(stackBoundary, 6'h24)
        `CHK(vectorPointer, 4'hA)
        `CHK(limitPending, 1'b0)
        `CHK(dataOeN, 1'b1)
        // No request or recognition is driven in this task
        run(`ISCS_OP_VECTOR_WRITE, 16'hFE00);
        `CHK(vectorPointer, 4'hB)
        run(`ISCS_OP_LIMIT_PTR_LOAD, 16'hA000);
        `CHK(vectorOut, 16'hFE00)
        `CHK(stackBoundary, 6'h00)
    endtask
    task automatic capture_modes();
        reqPulse(8'h81);
        `CHK(extPending, 8'h81)
        pulseSet();
        run(`ISCS_OP_TRANSPARENT, 16'h0000);
        `CHK(transparentMode, 1'b1)
        `CHK(extPending, 8'h00)
        `CHK(limitPending, 1'b1)
        run(`ISCS_OP_LATCHED, 16'h0000);
        `CHK(transparentMode, 1'b0)
    endtask
    task automatic service_return();
        run(`ISCS_OP_STACK_PUSH, 16'h2345);
        reqPulse(8'h0C);
        `CHK(extPending, 8'h0C)
        recognizedLevel = 4'h3;
        recognize = 1'b1;
        @(posedge clk);
        #1 recognize = 1'b0;
        `CHK(serviceInProgress, 1'b1)
        run(`ISCS_OP_SERVICE_RETURN, 16'h0000);
        `CHK(nextAddr, 16'h2345)
        `CHK(extPending, 8'h08)
        `CHK(serviceInProgress, 1'b0)
        `CHK(limitPending, 1'b1)
        ptrChk(6'h02);
    endtask
    task automatic transparent_hold();
        run(`ISCS_OP_TRANSPARENT, 16'h0000);
        extReq = 8'h10;
        repeat (6) @(posedge clk);
        #1 recognizedLevel = 4'h5;
        recognize = 1'b1;
        `CHK(extPending, 8'h00)
        @(posedge clk);
        #1 recognize = 1'b0;
        extReq = 8'h00;
        `CHK(serviceInProgress, 1'b1)
        repeat (4) @(posedge clk);
        #1;
        run(`ISCS_OP_LATCHED, 16'h0000);
        repeat (6) @(posedge clk);
        #1;
        `CHK(extPending, 8'h00)
    endtask
    initial begin
        rstn = 1'b0;
        extReq = 8'h00;
        limitSet = 1'b0;
        recognize = 1'b0;
        recognizedLevel = 4'h0;
        repeat (20) @(posedge clk);
        #1 rstn = 1'b1;
        stack_wrap();
        stack_dec();
        limit_vector();
        capture_modes();
        service_return();
        transparent_hold();
        print_verdict();
    end
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
